// ---- design/oto_defines.vh ----
// constants shared by the on-screen text overlay design files
`ifndef OTO_DEFINES_VH
`define OTO_DEFINES_VH

// register byte offsets on the bus
`define OTO_ADDR_DATA 8'h00
`define OTO_ADDR_ATTR 8'h04
`define OTO_ADDR_WADR 8'h08
`define OTO_ADDR_ORG 8'h0c
`define OTO_ADDR_CTRL 8'h10
`define OTO_ADDR_STAT 8'h14

// display memory geometry
`define OTO_RAM_DEPTH 128
`define OTO_RAM_AW 7
`define OTO_RAM_DW 10

// special character codes
`define OTO_CODE_NL 6'h3d
`define OTO_CODE_SPACE 6'h3c
`define OTO_CODE_BSP 6'h3e
`define OTO_CODE_SBSP 6'h3f

// control register fields
`define OTO_CTRL_EN 0
`define OTO_CTRL_NARROW 1
`define OTO_CTRL_NIDBL 2
`define OTO_CTRL_SHLO 4
`define OTO_CTRL_SHHI 6
`define OTO_CTRL_POL_HS 8
`define OTO_CTRL_POL_VS 9
`define OTO_CTRL_POL_COL 10
`define OTO_CTRL_POL_MIX 11
`define OTO_CTRL_MASK 32'h00000f77
`define OTO_ORG_MASK 32'h0000071f
`define OTO_ATTR_MASK 32'h00000017

// row heights in scan lines and widths in dots
`define OTO_H_NORM 6'd18
`define OTO_H_DBL 6'd36
`define OTO_H_SHORT 6'd4
`define OTO_H_SHORT_DBL 6'd8
`define OTO_W_WIDE 4'd14
`define OTO_W_NARROW 4'd12
`define OTO_W_SPLIT_WIDE 4'd7
`define OTO_W_SPLIT_NARROW 4'd6

// dot divider and origin scaling
`define OTO_DOT_DIV 3'd4
`define OTO_DOT_HALF 3'd2
`define OTO_VSTEP_SHIFT 4
`define OTO_HSTEP_SHIFT 3

// one-hot engine states
`define OTO_ST_IDLE 5'h01
`define OTO_ST_HWAIT 5'h02
`define OTO_ST_RUN 5'h04
`define OTO_ST_LEND 5'h08
`define OTO_ST_DONE 5'h10

`endif

// ---- design/oto_dpram.v ----
// dual-ported display memory, one write port and one read port
`timescale 1ns/1ns
`default_nettype none
`include "oto_defines.vh"

module oto_dpram (
   // clock
   input wire clock_in,
   // write port
   input wire wr_en_in,
   input wire [`OTO_RAM_AW-1:0] wr_addr_in,
   input wire [`OTO_RAM_DW-1:0] wr_data_in,
   // read port
   input wire [`OTO_RAM_AW-1:0] rd_addr_in,
   output reg [`OTO_RAM_DW-1:0] rd_data_out
);

   reg [`OTO_RAM_DW-1:0] mem [0:`OTO_RAM_DEPTH-1];

   // no reset on the array: contents are undefined until software fills it
   always @(posedge clock_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   // independent read keeps display fetch running during cpu writes
   always @(posedge clock_in) begin
      rd_data_out <= mem[rd_addr_in];
   end

endmodule
`default_nettype wire

// ---- design/oto_overlay.v ----
// on-screen text overlay engine with ahb-lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "oto_defines.vh"

// Contract
// - 128x10 display memory, cpu writes anytime
// - word is 6-bit code plus 4 attributes
// - row terminator stops row, resumes after it
// - terminator variant ends all displayed rows
// - background colour per word, choice per character
// - vertical sync event offered to software
// - character shapes 18 lines by 14 dots
// - double height and width 36 by 28
// - non-interlaced double height 36 by 14
// - eight selectable shadowing modes
// - programmable polarity of sync inputs, colour and mix outputs
// - dot oscillator stopped low during hsync
// - dot oscillator independent of cpu timing
// - short row 4 lines tall, 8 in double height
// - 5-bit horizontal, 3-bit vertical start fields
// - 60 shapes, four codes reserved special
// - generator address is code plus line count
// - display memory is write only to cpu
// - three colour outputs plus mix control
// - alternative 12 dots per character mode
// - attribute write latches, data write stores word
// - write address increments after each data write
// - special code values 3d 3c 3e 3f
module oto_overlay (
   // clock and reset
   input wire clock_in,
   input wire arst_n_in,
   // ahb-lite slave
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   output wire [31:0] hrdata_out,
   output wire hreadyout_out,
   output wire hresp_out,
   // sync inputs
   input wire hsync_in,
   input wire vsync_in,
   // character generator
   output wire [10:0] cg_addr_out,
   input wire [13:0] cg_data_in,
   // video outputs
   output wire dot_osc_out,
   output wire [2:0] colour_out,
   output wire mix_out,
   output wire vsync_event_out
);

   reg [31:0] hrdata_r;
   reg [31:0] rd_mux;
   reg dp_wr_r;
   reg [7:0] dp_addr_r;
   reg [3:0] attr_r;
   reg [6:0] waddr_r;
   reg [4:0] hstart_r;
   reg [2:0] vstart_r;
   reg [11:0] ctrl_r;
   reg vs_flag_r;
   wire acc;
   wire wr_data;
   wire ram_we;
   wire [9:0] ram_wdata;
   wire [9:0] ram_q;

   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign hrdata_out = hrdata_r;
   // hsize ignored: only whole-word transfers are supported
   assign acc = hsel_in & htrans_in[1] & hready_in;
   assign wr_data = dp_wr_r & (dp_addr_r == `OTO_ADDR_DATA);

   // engine state used by the status read
   reg [4:0] st_r;
   reg [6:0] ptr_r;
   reg vs_ev;

   always @* begin
      case (haddr_in[7:0])
         `OTO_ADDR_ATTR: rd_mux = {28'h0000000, attr_r};
         `OTO_ADDR_WADR: rd_mux = {25'h0000000, waddr_r};
         `OTO_ADDR_ORG: rd_mux = {21'h000000, vstart_r, 3'h0, hstart_r};
         `OTO_ADDR_CTRL: rd_mux = {20'h00000, ctrl_r};
         `OTO_ADDR_STAT: rd_mux = {16'h0000, 1'b0, ptr_r, 6'h00,
                                   st_r[4], vs_flag_r};
         // display memory itself cannot be read back
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dp_wr_r <= 1'b0;
         dp_addr_r <= 8'h00;
         hrdata_r <= 32'h00000000;
      end else begin
         dp_wr_r <= acc & hwrite_in;
         if (acc) begin
            dp_addr_r <= haddr_in[7:0];
         end
         if (acc & ~hwrite_in) begin
            hrdata_r <= rd_mux;
         end
      end
   end

   // attribute bits 4 and 2:0 pack into the upper word nibble
   assign ram_we = wr_data;
   assign ram_wdata = {attr_r, hwdata_in[5:0]};

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         attr_r <= 4'h0;
         waddr_r <= 7'h00;
         hstart_r <= 5'h00;
         vstart_r <= 3'h0;
         ctrl_r <= 12'h000;
         vs_flag_r <= 1'b0;
      end else begin
         if (dp_wr_r & (dp_addr_r == `OTO_ADDR_ATTR)) begin
            attr_r <= {hwdata_in[4], hwdata_in[2:0]};
         end
         if (dp_wr_r & (dp_addr_r == `OTO_ADDR_WADR)) begin
            waddr_r <= hwdata_in[6:0];
         end else if (wr_data) begin
            waddr_r <= waddr_r + 7'h01;
         end
         if (dp_wr_r & (dp_addr_r == `OTO_ADDR_ORG)) begin
            hstart_r <= hwdata_in[4:0];
            vstart_r <= hwdata_in[10:8];
         end
         if (dp_wr_r & (dp_addr_r == `OTO_ADDR_CTRL)) begin
            ctrl_r <= hwdata_in[11:0];
         end
         // a new event wins over a same-cycle clear
         vs_flag_r <= vs_ev | (vs_flag_r & ~(dp_wr_r & hwdata_in[0] &
                      (dp_addr_r == `OTO_ADDR_STAT)));
      end
   end

   oto_dpram u_ram (
      .clock_in(clock_in),
      .wr_en_in(ram_we),
      .wr_addr_in(waddr_r),
      .wr_data_in(ram_wdata),
      .rd_addr_in(ptr_r),
      .rd_data_out(ram_q)
   );

   // sync polarity: a set bit means the input is active low
   wire hs_a = hsync_in ^ ctrl_r[`OTO_CTRL_POL_HS];
   wire vs_a = vsync_in ^ ctrl_r[`OTO_CTRL_POL_VS];
   reg hs_d_r;
   reg vs_d_r;
   wire line_go = hs_d_r & ~hs_a;
   always @* vs_ev = vs_a & ~vs_d_r;
   assign vsync_event_out = vs_ev;

   // dot divider restarts on the trailing edge of hsync
   reg [2:0] div_r;
   reg osc_r;
   wire [2:0] div_nxt = (div_r == `OTO_DOT_DIV - 3'd1) ? 3'd0 : div_r + 3'd1;
   wire dot_en = ~hs_a & (div_r == `OTO_DOT_DIV - 3'd1);
   assign dot_osc_out = osc_r;

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         hs_d_r <= 1'b0;
         vs_d_r <= 1'b0;
         div_r <= 3'd0;
         osc_r <= 1'b0;
      end else begin
         hs_d_r <= hs_a;
         vs_d_r <= vs_a;
         if (hs_a) begin
            div_r <= 3'd0;
            osc_r <= 1'b0;
         end else begin
            // free of the bus side: only hsync steers it
            div_r <= div_nxt;
            osc_r <= (div_nxt < `OTO_DOT_HALF);
         end
      end
   end

   // row attributes and pending ones from the last terminator
   reg row_sr_r, row_d_r, row_sh_r;
   reg pend_e_r, pend_sr_r, pend_d_r, pend_sh_r;
   reg nl_seen_r, rows_on_r, hf_r;
   reg [6:0] base_r, next_base_r;
   reg [5:0] lrow_r;
   reg [8:0] vline_r;
   reg [7:0] hcnt_r;
   reg f1_r, f2_r, nready_r, cur_valid_r, wphase_r, split_r;
   reg [9:0] nword_r, cur_word_r;
   reg [13:0] nbits_r, cur_bits_r;
   reg [3:0] dots_r;
   reg [10:0] cg_addr_r;
   reg bg_b_r;
   reg [2:0] bg_col_r;

   wire dbl_v = row_d_r | ctrl_r[`OTO_CTRL_NIDBL];
   wire [5:0] height = row_sr_r ? (dbl_v ? `OTO_H_SHORT_DBL : `OTO_H_SHORT)
                       : (dbl_v ? `OTO_H_DBL : `OTO_H_NORM);
   wire [4:0] cg_line = dbl_v ? lrow_r[5:1] : lrow_r[4:0];
   wire narrow = ctrl_r[`OTO_CTRL_NARROW];
   wire [3:0] width = narrow ? `OTO_W_NARROW : `OTO_W_WIDE;
   wire [3:0] half = narrow ? `OTO_W_SPLIT_NARROW : `OTO_W_SPLIT_WIDE;
   wire step = ~row_d_r | wphase_r;
   wire last = ~cur_valid_r | ((dots_r == 4'd1) & step);
   wire [8:0] vtop = {6'h00, vstart_r} << `OTO_VSTEP_SHIFT;
   wire [7:0] htop = {3'h0, hstart_r} << `OTO_HSTEP_SHIFT;
   wire is_space = (nword_r[5:0] == `OTO_CODE_SPACE) |
                   (nword_r[5:0] == `OTO_CODE_BSP) |
                   (nword_r[5:0] == `OTO_CODE_SBSP);
   wire load = (st_r == `OTO_ST_RUN) & dot_en & last & nready_r;
   wire hgo = (st_r == `OTO_ST_HWAIT) & ~hf_r;
   wire fetch_go = load | hgo;

   assign cg_addr_out = cg_addr_r;

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_r <= `OTO_ST_IDLE;
         ptr_r <= 7'h00;
         base_r <= 7'h00;
         next_base_r <= 7'h00;
         lrow_r <= 6'h00;
         vline_r <= 9'h000;
         hcnt_r <= 8'h00;
         {row_sr_r, row_d_r, row_sh_r} <= 3'h0;
         {pend_e_r, pend_sr_r, pend_d_r, pend_sh_r} <= 4'h0;
         {nl_seen_r, rows_on_r, hf_r} <= 3'h0;
         {f1_r, f2_r, nready_r, cur_valid_r, wphase_r, split_r} <= 6'h00;
         nword_r <= 10'h000;
         cur_word_r <= 10'h000;
         nbits_r <= 14'h0000;
         cur_bits_r <= 14'h0000;
         dots_r <= 4'h0;
         cg_addr_r <= 11'h000;
         bg_b_r <= 1'b0;
         bg_col_r <= 3'h0;
      end else if (vs_ev | ~ctrl_r[`OTO_CTRL_EN]) begin
         st_r <= `OTO_ST_IDLE;
         ptr_r <= 7'h00;
         base_r <= 7'h00;
         lrow_r <= 6'h00;
         vline_r <= 9'h000;
         {row_sr_r, row_d_r, row_sh_r} <= 3'h0;
         {nl_seen_r, rows_on_r, hf_r} <= 3'h0;
         {f1_r, f2_r, nready_r, cur_valid_r, split_r} <= 5'h00;
         bg_b_r <= 1'b0;
         bg_col_r <= 3'h0;
      end else if (line_go) begin
         vline_r <= vline_r + 9'h001;
         hcnt_r <= 8'h00;
         {f1_r, f2_r, nready_r, cur_valid_r, hf_r} <= 5'h00;
         nl_seen_r <= 1'b0;
         if (st_r == `OTO_ST_DONE) begin
            st_r <= `OTO_ST_DONE;
         end else if (rows_on_r) begin
            if (lrow_r == height - 6'd1) begin
               lrow_r <= 6'h00;
               if (nl_seen_r) begin
                  base_r <= next_base_r;
                  ptr_r <= next_base_r;
                  row_sr_r <= pend_sr_r;
                  row_d_r <= pend_d_r;
                  row_sh_r <= pend_sh_r;
                  st_r <= pend_e_r ? `OTO_ST_DONE : `OTO_ST_HWAIT;
               end else begin
                  ptr_r <= base_r;
                  st_r <= `OTO_ST_HWAIT;
               end
            end else begin
               lrow_r <= lrow_r + 6'h01;
               ptr_r <= base_r;
               st_r <= `OTO_ST_HWAIT;
            end
         end else if (vline_r == vtop) begin
            rows_on_r <= 1'b1;
            ptr_r <= base_r;
            st_r <= `OTO_ST_HWAIT;
         end
      end else begin
         // fetch: word, then generator lookup
         f1_r <= fetch_go;
         f2_r <= 1'b0;
         if (hgo) begin
            hf_r <= 1'b1;
         end
         if (f1_r) begin
            if (ram_q[5:0] == `OTO_CODE_NL) begin
               nl_seen_r <= 1'b1;
               next_base_r <= ptr_r + 7'h01;
               {pend_e_r, pend_sr_r, pend_d_r, pend_sh_r} <= ram_q[9:6];
            end else begin
               cg_addr_r <= {ram_q[5:0], cg_line};
               nword_r <= ram_q;
               ptr_r <= ptr_r + 7'h01;
               f2_r <= 1'b1;
            end
         end
         if (f2_r) begin
            // reserved codes have no shape of their own
            nbits_r <= is_space ? 14'h0000 :
                       (narrow ? {cg_data_in[12:0], 1'b0} : cg_data_in);
            nready_r <= 1'b1;
         end
         if ((st_r == `OTO_ST_HWAIT) & dot_en) begin
            if (hcnt_r == htop) begin
               st_r <= `OTO_ST_RUN;
            end else begin
               hcnt_r <= hcnt_r + 8'h01;
            end
         end
         if ((st_r == `OTO_ST_RUN) & dot_en) begin
            if (last) begin
               wphase_r <= 1'b0;
               if (nready_r) begin
                  cur_word_r <= nword_r;
                  cur_bits_r <= nbits_r;
                  dots_r <= width;
                  cur_valid_r <= 1'b1;
                  nready_r <= 1'b0;
                  split_r <= (nword_r[5:0] == `OTO_CODE_SBSP);
                  if (nword_r[5:0] == `OTO_CODE_BSP) begin
                     bg_b_r <= nword_r[9];
                     bg_col_r <= nword_r[8:6];
                  end
               end else begin
                  cur_valid_r <= 1'b0;
                  // terminator fetched: blank until next line
                  if (nl_seen_r & ~f1_r & ~f2_r) begin
                     st_r <= `OTO_ST_LEND;
                  end
               end
            end else begin
               wphase_r <= row_d_r & ~wphase_r;
               if (step) begin
                  cur_bits_r <= {cur_bits_r[12:0], 1'b0};
                  dots_r <= dots_r - 4'h1;
                  if (split_r & (dots_r == half + 4'h1)) begin
                     bg_b_r <= cur_word_r[9];
                     bg_col_r <= cur_word_r[8:6];
                  end
               end
            end
         end
      end
   end

   // pixel shaping and output polarity
   reg [1:0] prev_r;
   reg [2:0] col_r;
   reg mix_r;
   wire show = (st_r == `OTO_ST_RUN) & cur_valid_r;
   wire pix = show & cur_bits_r[13];
   wire cur_space = (cur_word_r[5:0] >= `OTO_CODE_SPACE);
   wire bsel = show & (cur_space ? bg_b_r : cur_word_r[9]);
   wire [2:0] sh_mode = ctrl_r[`OTO_CTRL_SHHI:`OTO_CTRL_SHLO];
   wire sh_hit = show & row_sh_r & ~bsel & ~pix &
                 ((sh_mode[0] & prev_r[0]) | (sh_mode[1] & cur_bits_r[12]) |
                  (sh_mode[2] & prev_r[1]));
   wire [2:0] col_v = pix ? (cur_space ? bg_col_r : cur_word_r[8:6]) :
                      (bsel & ~sh_hit) ? bg_col_r : 3'h0;
   wire mix_v = pix | sh_hit | bsel;

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prev_r <= 2'h0;
         col_r <= 3'h0;
         mix_r <= 1'b0;
      end else begin
         if (dot_en & step) begin
            prev_r <= {prev_r[0], pix};
         end
         col_r <= col_v ^ {3{ctrl_r[`OTO_CTRL_POL_COL]}};
         mix_r <= mix_v ^ ctrl_r[`OTO_CTRL_POL_MIX];
      end
   end

   assign colour_out = col_r;
   assign mix_out = mix_r;

endmodule
`default_nettype wire

// ---- test/onscreen_text_overlay_tb_top.sv ----
// testbench: bus accesses, register checks and lit clock counts per frame
`timescale 1ns/1ns
`default_nettype none
`include "oto_defines.vh"
module onscreen_text_overlay_tb_top;
   logic clock_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic hsel_in = 1'b0;
   logic [31:0] haddr_in = 32'h0;
   logic [1:0] htrans_in = 2'h0;
   logic hwrite_in = 1'b0;
   logic [2:0] hsize_in = 3'h0;
   logic [31:0] hwdata_in = 32'h0;
   wire [31:0] hrdata_out;
   wire hready_in;
   wire hsync_in, vsync_in, dot_osc_out, mix_out, vsync_event_out;
   wire [10:0] cg_addr_out;
   wire [13:0] cg_data_in;
   wire [2:0] colour_out;
   int miscompares = 0;
   int compares = 0;
   oto_overlay u_dut (.clock_in, .arst_n_in, .hsel_in, .haddr_in,
      .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in,
      .hrdata_out, .hreadyout_out(hready_in), .hresp_out(), .hsync_in,
      .vsync_in, .cg_addr_out, .cg_data_in, .dot_osc_out, .colour_out,
      .mix_out, .vsync_event_out);
   oto_video_src u_src (.clock_in, .arst_n_in, .hs_out(hsync_in),
      .vs_out(vsync_in), .cg_addr_in(cg_addr_out), .cg_data_out(cg_data_in));
   initial begin
      forever #2 clock_in = ~clock_in;
   end
   task automatic end_sim;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // single transfer; each phase held until hready is sampled high
   task automatic bus(logic wr, logic [7:0] a, logic [31:0] d,
      output logic [31:0] q);
      @(posedge clock_in);
      hsel_in <= 1'b1;
      htrans_in <= 2'h2;
      hsize_in <= 3'h2;
      hwrite_in <= wr;
      haddr_in <= {24'h0, a};
      do @(posedge clock_in); while (hready_in !== 1'b1);
      htrans_in <= 2'h0;
      hwdata_in <= d;
      do @(posedge clock_in); while (hready_in !== 1'b1);
      q = hrdata_out;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(string w, logic [7:0] a, logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(w, q, e);
   endtask
   // counts settled clocks with mix active up to the next vsync event
   task automatic frame(logic [11:0] c, output int act, output int bad);
      act = 0;
      bad = 0;
      // new polarity needs a clock to reach the registered outputs
      repeat (2) @(posedge clock_in);
      forever begin
         @(negedge clock_in);
         if (vsync_event_out === 1'b1) break;
         if (mix_out === ~c[11]) begin
            act++;
            if (colour_out !== (3'h5 ^ {3{c[10]}})) bad++;
         end
      end
   endtask
   initial begin
      logic [11:0] ctl [7] = '{12'h001, 12'h003, 12'h005, 12'h801,
         12'h001, 12'h001, 12'h401};
      // words as {attribute, code}: one lit character, then end marker; tests 4 and 5 open with a row terminator
      logic [15:0] prg [7][3] = '{'{16'h0501, 16'h103d, 16'h103d},
         '{16'h0501, 16'h103d, 16'h103d}, '{16'h0501, 16'h103d, 16'h103d},
         '{16'h0501, 16'h103d, 16'h103d}, '{16'h023d, 16'h0501, 16'h103d},
         '{16'h043d, 16'h0501, 16'h103d}, '{16'h0501, 16'h103d, 16'h103d}};
      int exp [7] = '{1008, 864, 2016, 1008, 4032, 224, 1008};
      int act;
      int bad;
      logic [31:0] q;
      repeat (16) @(posedge clock_in);
      arst_n_in <= 1'b1;
      rdc("attr reset", `OTO_ADDR_ATTR, 32'h0);
      rdc("ctrl reset", `OTO_ADDR_CTRL, 32'h0);
      wr(`OTO_ADDR_ATTR, 32'hff);
      rdc("attr bits", `OTO_ADDR_ATTR, 32'hf);
      wr(`OTO_ADDR_ORG, 32'hffff);
      rdc("origin bits", `OTO_ADDR_ORG, 32'h71f);
      wr(`OTO_ADDR_ORG, 32'h0);
      wr(`OTO_ADDR_WADR, 32'h7f);
      wr(`OTO_ADDR_DATA, 32'h3c);
      rdc("wadr wrap", `OTO_ADDR_WADR, 32'h0);
      wr(`OTO_ADDR_DATA, 32'h3c);
      wr(`OTO_ADDR_DATA, 32'h3c);
      rdc("wadr step", `OTO_ADDR_WADR, 32'h2);
      rdc("data read", `OTO_ADDR_DATA, 32'h0);
      rdc("unmapped", 8'h40, 32'h0);
      // reprogram inside vertical blanking so each test costs one frame
      @(negedge clock_in iff vsync_event_out === 1'b1);
      for (int t = 0; t < 7; t++) begin
         wr(`OTO_ADDR_CTRL, 32'h0);
         wr(`OTO_ADDR_WADR, 32'h0);
         for (int k = 0; k < 3; k++) begin
            wr(`OTO_ADDR_ATTR, {24'h0, prg[t][k][15:8]});
            wr(`OTO_ADDR_DATA, {24'h0, prg[t][k][7:0]});
         end
         wr(`OTO_ADDR_CTRL, {20'h0, ctl[t]});
         frame(ctl[t], act, bad);
         check("lit clocks", act, exp[t]);
         check("fg colour", bad, 0);
      end
      bus(1'b0, `OTO_ADDR_STAT, 32'h0, q);
      check("vsync flag", q & 32'h1, 32'h1);
      wr(`OTO_ADDR_STAT, 32'h1);
      bus(1'b0, `OTO_ADDR_STAT, 32'h0, q);
      check("vsync clear", q & 32'h1, 32'h0);
      end_sim();
   end
   initial begin
      #360000;
      miscompares++;
      end_sim();
   end
endmodule
`default_nettype wire

// ---- test/oto_checker.sv ----
// port assertions for the text overlay, bound to its top module
`timescale 1ns/1ns
`default_nettype none
`include "oto_defines.vh"
module oto_checker (
   // clock and reset
   input wire logic clock_in,
   input wire logic arst_n_in,
   // register bus
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_out,
   // video
   input wire logic hsync_in,
   input wire logic [10:0] cg_addr_out,
   input wire logic dot_osc_out,
   input wire logic mix_out,
   input wire logic vsync_event_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);
   // shadow copies of writable registers, so polarity is known here
   logic wr_r;
   logic [7:0] ad_r;
   logic [11:0] ctl_r;
   logic [4:0] at_r;
   logic [6:0] wp_r;
   wire hs_act = hsync_in ^ ctl_r[8];
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_r <= 1'b0;
         ad_r <= 8'h00;
         ctl_r <= 12'h000;
         at_r <= 5'h00;
         wp_r <= 7'h00;
      end else begin
         wr_r <= hsel_in && htrans_in[1] && hwrite_in && hready_in;
         ad_r <= haddr_in[7:0];
         if (wr_r && ad_r == `OTO_ADDR_CTRL) ctl_r <= hwdata_in[11:0];
         if (wr_r && ad_r == `OTO_ADDR_ATTR) at_r <= hwdata_in[4:0] & 5'h17;
         if (wr_r && ad_r == `OTO_ADDR_DATA) wp_r <= wp_r + 7'h01;
         if (wr_r && ad_r == `OTO_ADDR_WADR) wp_r <= hwdata_in[6:0];
      end
   end
   sequence rd_s(logic [7:0] a);
      hsel_in && htrans_in[1] && !hwrite_in && hready_in && haddr_in[7:0] == a;
   endsequence
   // sync path may add a few flops, hence the held window
   sequence hs_held_s;
      hs_act [*4];
   endsequence
   sequence run_s;
      (ctl_r[0] && !hs_act) [*8];
   endsequence
   data_wonly_a: assert property (rd_s(`OTO_ADDR_DATA) |=>
      hrdata_out == 32'h0) else $error("data register read not zero");
   attr_latch_a: assert property (rd_s(`OTO_ADDR_ATTR) |=>
      hrdata_out == {28'h0, at_r[4], at_r[2:0]})
      else $error("attribute latch lost");
   wadr_step_a: assert property (rd_s(`OTO_ADDR_WADR) |=>
      hrdata_out[6:0] == wp_r) else $error("write address step wrong");
   dot_stop_a: assert property (hs_held_s |-> !dot_osc_out)
      else $error("dot clock runs during hsync");
   dot_run_a: assert property (run_s |-> ##[0:3] $changed(dot_osc_out))
      else $error("dot clock stuck outside hsync");
   vs_pulse_a: assert property (vsync_event_out |=> !vsync_event_out)
      else $error("vsync event longer than one cycle");
   mix_idle_a: assert property (!ctl_r[0] [*3] |-> mix_out == ctl_r[11])
      else $error("mix active while engine off");
   line_range_a: assert property (cg_addr_out[4:0] <= 5'd17)
      else $error("generator line beyond shape height");
endmodule
bind oto_overlay oto_checker u_chk (.clock_in, .arst_n_in, .hsel_in,
   .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hrdata_out,
   .hsync_in, .cg_addr_out, .dot_osc_out, .mix_out, .vsync_event_out);
`default_nettype wire

// ---- test/oto_video_src.sv ----
// sync sources and character generator facing the overlay
`timescale 1ns/1ns
`default_nettype none
module oto_video_src #(
   parameter int LINE_CLK = 160,
   parameter int HS_CLK = 16,
   parameter int LINES = 58
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic arst_n_in,
   // syncs, active high
   output logic hs_out,
   output logic vs_out,
   // character generator
   input wire logic [10:0] cg_addr_in,
   output logic [13:0] cg_data_out
);
   logic [7:0] h_r;
   logic [6:0] l_r;
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         h_r <= 8'h00;
         l_r <= 7'h00;
      end else if (h_r == 8'(LINE_CLK - 1)) begin
         h_r <= 8'h00;
         l_r <= (l_r == 7'(LINES - 1)) ? 7'h00 : l_r + 7'h01;
      end else begin
         h_r <= h_r + 8'h01;
      end
   end
   assign hs_out = h_r < 8'(HS_CLK);
   // vsync in the last, blank line so every row lies inside one frame
   assign vs_out = l_r == 7'(LINES - 1) && h_r >= 8'h50 && h_r < 8'h78;
   // one solid shape only, which makes lit dot counts exact
   assign cg_data_out = cg_addr_in[10:5] == 6'h01 ? 14'h3fff : 14'h0000;
endmodule
`default_nettype wire
